// file: hdl/prt_pkg.sv
// Package for the prescaled reload timer: register indices, field positions,
// reset values and the reference-tick timing constants.
// Assumes a 32-bit APB slave with one aligned word per register index.
package prt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE     = 6'h2a;
  localparam logic [5:0] IDX_PRE_LO   = 6'h2b;
  localparam logic [5:0] IDX_RLD_HI   = 6'h2c;
  localparam logic [5:0] IDX_RLD_LO   = 6'h2d;
  localparam logic [5:0] IDX_CNT_HI   = 6'h2e;
  localparam logic [5:0] IDX_CNT_LO   = 6'h2f;
  localparam logic [5:0] IDX_CTRL     = 6'h3c;
  localparam logic [5:0] IDX_STATUS   = 6'h3d;

  // Mode register fields
  localparam int MODE_AUTO_BIT    = 7;
  localparam int MODE_GATE_HI     = 6;
  localparam int MODE_GATE_LO     = 5;
  localparam int MODE_RESTART_BIT = 4;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HALT_BIT  = 1;
  localparam int CTRL_EVEN_BIT  = 2;
  localparam int CTRL_MULTI_BIT = 3;
  localparam int CTRL_INIT_BIT  = 4;

  // Status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_IRQ_BIT    = 1;

  // Gating source encodings
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_SIG  = 2'h1;
  localparam logic [1:0] GATE_AUX  = 2'h2;
  localparam logic [1:0] GATE_A3   = 2'h3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Received-bit stop points for automatic start
  localparam logic [2:0] STOP_BITS_106   = 3'h5;
  localparam logic [2:0] STOP_BITS_OTHER = 3'h4;

  // Reference tick: 13.56 MHz made from the system clock by a fraction
  localparam int REF_KHZ       = 13560;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CLK_KHZ       = 1000000000 / CLK_PERIOD_PS;
  localparam logic [16:0] FRAC_INC = 17'(REF_KHZ);
  localparam logic [16:0] FRAC_MOD = 17'(CLK_KHZ);

endpackage

// file: hdl/prt_timer.sv
// Prescaled reload timer with its APB register slave.
// Assumes a 125 MHz clk; gate pins arrive asynchronously, protocol
// event inputs come from logic on the same clock.
// Reset values come from the package; the counter resets to zero.
//
// Contract
// - Two-bit gate field: none, signal input, auxiliary pin, or address pin A3.
// - In gated mode the active flag shows the enable, not the gate level.
// - With auto reload set the counter reloads at zero and keeps counting.
// - With auto reload clear the counter stops at zero and sets the irq flag.
// - Prescale value is the mode nibble above the prescale low byte, 12 bits.
// - Odd mode: tick rate is 13.56 MHz over twice prescale plus one.
// - Even mode: tick rate is 13.56 MHz over twice prescale plus two.
// - Even divide select is zero after reset.
// - Reload value is 16 bits in a high and a low byte register.
// - Every start event copies the reload value into the counter.
// - Reload writes do not touch a running count; used at next start.
// - Two read-only registers return the live counter high and low bytes.
// - Auto start fires on end of transmit or field on with initial field enabled.
// - Auto start without multi receive stops after bit 5 (106 modes) or 4.
// - Auto start with multi receive never stops on reception; halt does, or zero with auto reload clear.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps

module prt_timer
  import prt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              signal_input_pin,
  input  wire logic              auxiliary_pin_one,
  input  wire logic              addr_a3_pin,
  input  wire logic              tx_end,
  input  wire logic              field_on,
  input  wire logic              rx_bit,
  input  wire logic              rx_106_mode,
  output logic                   timer_active_flag,
  output logic                   timer_irq_flag
);

  typedef struct packed {
    // Gate pin synchroniser stages
    logic [2:0]  gate_meta;
    logic [2:0]  gate_sync;
    // Timer core
    logic [16:0] frac;
    logic [12:0] pre_cnt;
    logic [15:0] count;
    logic        running;
    logic [2:0]  rx_bits;
    logic        irq;
    // Software-visible registers
    logic [7:0]  mode;
    logic [7:0]  pre_lo;
    logic [7:0]  rld_hi;
    logic [7:0]  rld_lo;
    logic        even_sel;
    logic        multi_rx;
    logic        init_field;
    // APB answer
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
  } prt_state_t;

  prt_state_t s_r;
  prt_state_t s_nxt;

  logic [1:0]  rst_sync_r;
  logic        rst_n;

  // APB decode
  logic        acc_wr;
  logic        acc_rd;
  logic [5:0]  acc_idx;
  logic        mapped;
  logic [31:0] rd_word;
  // Timer datapath
  logic        gate_ok;
  logic        ref_tick;
  logic        timer_tick;
  logic [11:0] prescale_value;
  logic [12:0] pre_limit;
  logic        sw_start;
  logic        halt_now;
  logic        auto_start;
  logic        start_evt;
  logic        count_zero;
  logic [2:0]  rx_limit;
  logic [17:0] frac_sum;

  // Word index of an APB byte address
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[7:2];
  endfunction

  // True when an index names a register of this block
  function automatic logic idx_mapped(input logic [5:0] i);
    idx_mapped = (i >= IDX_MODE && i <= IDX_CNT_LO) || i == IDX_CTRL || i == IDX_STATUS;
  endfunction

  // Gate source field of a mode byte
  function automatic logic [1:0] gate_field(input logic [7:0] m);
    gate_field = m[MODE_GATE_HI:MODE_GATE_LO];
  endfunction

  // Reload word from its two bytes; loaded on start and on auto reload
  function automatic logic [15:0] reload_word(input logic [7:0] hi, input logic [7:0] lo);
    reload_word = {hi, lo};
  endfunction

  // Reset release through two flops so deassertion is clean
  // The first stage may settle late; nothing but the second reads it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // Next-state logic for all timer and register state
  always_comb begin
    s_nxt          = s_r;
    acc_idx        = reg_index(paddr);
    mapped         = idx_mapped(acc_idx);
    // Write lands on the edge where the master sees pready
    acc_wr         = psel && penable && s_r.ready && pwrite && mapped;
    acc_rd         = psel && penable && !s_r.ready && !pwrite;
    rd_word        = 32'h0000_0000;
    gate_ok        = 1'b1;
    ref_tick       = 1'b0;
    timer_tick     = 1'b0;
    prescale_value = {s_r.mode[3:0], s_r.pre_lo};
    pre_limit      = 13'h0000;
    sw_start       = 1'b0;
    halt_now       = 1'b0;
    auto_start     = 1'b0;
    start_evt      = 1'b0;
    count_zero     = 1'b0;
    rx_limit       = STOP_BITS_OTHER;

    // Gate pins pass two flops; only the second stage is read
    s_nxt.gate_meta = {addr_a3_pin, auxiliary_pin_one, signal_input_pin};
    s_nxt.gate_sync = s_r.gate_meta;

    // Gate source select; the active flag never feeds back here
    // Gating acts after the synchroniser, two clocks after the pin moves
    if (gate_field(s_r.mode) == GATE_SIG) begin
      gate_ok = s_r.gate_sync[0];
    end else if (gate_field(s_r.mode) == GATE_AUX) begin
      gate_ok = s_r.gate_sync[1];
    end else if (gate_field(s_r.mode) == GATE_A3) begin
      gate_ok = s_r.gate_sync[2];
    end else begin
      gate_ok = 1'b1;
    end

    // Fractional accumulator makes a 13.56 MHz enable from 125 MHz;
    // tick edges jitter by one clk but the long-run rate is exact
    // The sum is one bit wider: near the modulus it overflows 17 bits
    frac_sum = 18'(s_r.frac) + 18'(FRAC_INC);
    if (frac_sum >= 18'(FRAC_MOD)) begin
      s_nxt.frac = 17'(frac_sum - 18'(FRAC_MOD));
      ref_tick   = 1'b1;
    end else begin
      s_nxt.frac = 17'(frac_sum);
    end

    // Divide by 2P+1 in odd mode, 2P+2 in even mode
    // pre_cnt is one bit wider than the prescale value so 2P+1 fits
    if (s_r.even_sel) begin
      pre_limit = {prescale_value, 1'b1};
    end else begin
      pre_limit = {prescale_value, 1'b0};
    end

    // Prescaler and counter hold while the gate is low
    if (s_r.running && gate_ok && ref_tick) begin
      if (s_r.pre_cnt >= pre_limit) begin
        s_nxt.pre_cnt = 13'h0000;
        timer_tick    = 1'b1;
      end else begin
        s_nxt.pre_cnt = s_r.pre_cnt + 13'h0001;
      end
    end

    // Software writes to the control register: start and halt strobes
    if (acc_wr && acc_idx == IDX_CTRL) begin
      sw_start = pwdata[CTRL_START_BIT];
      halt_now = pwdata[CTRL_HALT_BIT];
    end

    // Protocol-driven start
    auto_start = s_r.mode[MODE_AUTO_BIT] && (tx_end || (field_on && s_r.init_field));
    start_evt  = sw_start || auto_start;

    // Counter: reaching zero either reloads or stops
    // A reload of zero still gives one tick before the flag
    count_zero = (s_r.count == 16'h0001) || (s_r.count == 16'h0000);
    if (timer_tick) begin
      if (count_zero) begin
        s_nxt.irq = 1'b1;
        if (s_r.mode[MODE_RESTART_BIT]) begin
          s_nxt.count = reload_word(s_r.rld_hi, s_r.rld_lo);
        end else begin
          s_nxt.count   = 16'h0000;
          s_nxt.running = 1'b0;
        end
      end else begin
        s_nxt.count = s_r.count - 16'h0001;
      end
    end

    // Receive bits stop an auto-started timer unless multi receive is on
    // Only bits seen while running count; each start clears the tally
    rx_limit = rx_106_mode ? STOP_BITS_106 : STOP_BITS_OTHER;
    if (s_r.running && s_r.mode[MODE_AUTO_BIT] && !s_r.multi_rx && rx_bit) begin
      s_nxt.rx_bits = s_r.rx_bits + 3'h1;
      if (s_r.rx_bits + 3'h1 >= rx_limit) begin
        s_nxt.running = 1'b0;
      end
    end

    // Halt beats a running count; a start in the same write wins
    // Halt is only a strobe; an irq raised in the same cycle stays
    if (halt_now) begin
      s_nxt.running = 1'b0;
    end
    if (start_evt) begin
      s_nxt.count   = reload_word(s_r.rld_hi, s_r.rld_lo);
      s_nxt.pre_cnt = 13'h0000;
      s_nxt.rx_bits = 3'h0;
      s_nxt.running = 1'b1;
    end

    // Register writes; reload bytes only stored, the count is untouched
    // Count registers take writes without effect
    if (acc_wr) begin
      if (acc_idx == IDX_MODE) begin
        s_nxt.mode = pwdata[7:0];
      end else if (acc_idx == IDX_PRE_LO) begin
        s_nxt.pre_lo = pwdata[7:0];
      end else if (acc_idx == IDX_RLD_HI) begin
        s_nxt.rld_hi = pwdata[7:0];
      end else if (acc_idx == IDX_RLD_LO) begin
        s_nxt.rld_lo = pwdata[7:0];
      end else if (acc_idx == IDX_CTRL) begin
        s_nxt.even_sel   = pwdata[CTRL_EVEN_BIT];
        s_nxt.multi_rx   = pwdata[CTRL_MULTI_BIT];
        s_nxt.init_field = pwdata[CTRL_INIT_BIT];
      end else if (acc_idx == IDX_STATUS) begin
        // Write one clears; a zero-reach in this cycle keeps the flag
        if (pwdata[STAT_IRQ_BIT] && !(timer_tick && count_zero)) begin
          s_nxt.irq = 1'b0;
        end
      end
    end

    // Read mux
    // Count bytes are read one at a time; a tick between reads can tear the pair
    if (acc_idx == IDX_MODE) begin
      rd_word[7:0] = s_r.mode;
    end else if (acc_idx == IDX_PRE_LO) begin
      rd_word[7:0] = s_r.pre_lo;
    end else if (acc_idx == IDX_RLD_HI) begin
      rd_word[7:0] = s_r.rld_hi;
    end else if (acc_idx == IDX_RLD_LO) begin
      rd_word[7:0] = s_r.rld_lo;
    end else if (acc_idx == IDX_CNT_HI) begin
      rd_word[7:0] = s_r.count[15:8];
    end else if (acc_idx == IDX_CNT_LO) begin
      rd_word[7:0] = s_r.count[7:0];
    end else if (acc_idx == IDX_CTRL) begin
      rd_word[CTRL_EVEN_BIT]  = s_r.even_sel;
      rd_word[CTRL_MULTI_BIT] = s_r.multi_rx;
      rd_word[CTRL_INIT_BIT]  = s_r.init_field;
    end else if (acc_idx == IDX_STATUS) begin
      rd_word[STAT_ACTIVE_BIT] = s_r.running;
      rd_word[STAT_IRQ_BIT]    = s_r.irq;
    end else begin
      rd_word = 32'h0000_0000;
    end

    // APB answer one cycle into the access phase
    // The wait state gives the read mux a registered cycle; pready lasts one clk
    s_nxt.ready  = psel && penable && !s_r.ready;
    s_nxt.slverr = psel && penable && !s_r.ready && !mapped;
    if (acc_rd) begin
      s_nxt.rdata = mapped ? rd_word : 32'h0000_0000;
    end
  end

  // Single state register; clock enable freezes everything
  // ce low also holds pready, so a frozen access simply waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Counter has no defined reset value; zero keeps early reads stable
      s_r.gate_meta  <= 3'h0;
      s_r.gate_sync  <= 3'h0;
      s_r.frac       <= 17'h00000;
      s_r.pre_cnt    <= 13'h0000;
      s_r.count      <= 16'h0000;
      s_r.running    <= 1'b0;
      s_r.rx_bits    <= 3'h0;
      s_r.irq        <= 1'b0;
      s_r.mode       <= RST_BYTE;
      s_r.pre_lo     <= RST_BYTE;
      s_r.rld_hi     <= RST_BYTE;
      s_r.rld_lo     <= RST_BYTE;
      s_r.even_sel   <= 1'b0;
      s_r.multi_rx   <= 1'b0;
      s_r.init_field <= 1'b0;
      s_r.ready      <= 1'b0;
      s_r.rdata      <= 32'h0000_0000;
      s_r.slverr     <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state flops
  // so nothing glitches while the next state settles
  assign pready            = s_r.ready;
  assign prdata            = s_r.rdata;
  assign pslverr           = s_r.slverr;
  assign timer_active_flag = s_r.running;
  assign timer_irq_flag    = s_r.irq;

endmodule // prt_timer

// file: bench/prt_timer_properties.sv
// Port checker for the prescaled reload timer.
// Assumes ce is held high, so every APB access answers in fixed time.
`timescale 1ns/100ps
module prt_properties
  import prt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              timer_active_flag,
  input wire logic              timer_irq_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Access strobes at the answering edge
  wire logic acc    = psel && penable && pready;
  wire logic wr_ctl = acc && pwrite && paddr[7:2] == IDX_CTRL;
  wire logic clr    = acc && pwrite && paddr[7:2] == IDX_STATUS && pwdata[STAT_IRQ_BIT];
  wire logic mapd   = paddr[7:2] inside {[IDX_MODE:IDX_CNT_LO], IDX_CTRL, IDX_STATUS};
  property p_ans; psel && !penable |=> !pready ##1 pready; endproperty
  a_ans: assert property (p_ans) else $error("late apb answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; acc |-> pslverr == !mapd; endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_hi0; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_start; wr_ctl && pwdata[CTRL_START_BIT] |=> timer_active_flag; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_halt; wr_ctl && pwdata[CTRL_HALT_BIT] && !pwdata[CTRL_START_BIT] |=> !timer_active_flag; endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_sticky; timer_irq_flag && !clr |=> timer_irq_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("irq lost");
  property p_clr; clr && !timer_active_flag |=> !timer_irq_flag; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_rise; $rose(timer_irq_flag) |-> $past(timer_active_flag); endproperty
  a_rise: assert property (p_rise) else $error("irq while idle");
endmodule // prt_properties

bind prt_timer prt_properties #(.ADDR_W(ADDR_W)) i_prt_properties (.clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .timer_active_flag, .timer_irq_flag);

// file: bench/prt_timer_test.sv
// Self-checking bench for the prescaled reload timer.
// Assumes the bound port checker; reads are compared by a monitor.
`timescale 1ns/100ps
module prt_timer_test
  import prt_pkg::*;
;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h1d0b;
  logic        pready, pslverr, timer_active_flag, timer_irq_flag;
  logic [2:0]  gpin = 3'h0;
  logic        tx_end = 0, field_on = 0, rx_bit = 0, rx_106_mode = 0;
  logic [33:0] q[$], mx;
  logic [5:0]  rr[6] = '{IDX_MODE, IDX_PRE_LO, IDX_RLD_HI, IDX_RLD_LO, IDX_CTRL, IDX_STATUS};
  int          n_mismatch = 0, checked = 0, cyc = 0;
  logic [7:0]  d;

  always #4 clk = ~clk;
  // Timeout cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results;
    end
  end

  prt_timer i_prt_timer (.clk, .arst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .signal_input_pin(gpin[0]), .auxiliary_pin_one(gpin[1]), .addr_a3_pin(gpin[2]),
    .tx_end, .field_on, .rx_bit, .rx_106_mode, .timer_active_flag, .timer_irq_flag);

  task results;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task check(input string nm, input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One APB transfer; the request is held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [33:0] e);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) q.push_back(e);
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [5:0] i, input logic [7:0] v); apb(1, {i, 2'b00}, {24'h0, v}, '0); endtask
  task rd(input logic [5:0] i, input logic [7:0] v, input logic sk); apb(0, {i, 2'b00}, 0, {sk, 25'h0, v}); endtask

  // Answers are matched in order against the noted expectations
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      mx = q.pop_front();
      if (!mx[33]) check("read", {pslverr, prdata}, mx[32:0]);
    end
  end

  // One-clock strobe on the protocol inputs: bit 0 tx_end, 1 field_on, 2 rx_bit
  task pulse(input logic [2:0] m);
    @(posedge clk);
    {rx_bit, field_on, tx_end} <= m;
    @(posedge clk);
    {rx_bit, field_on, tx_end} <= 3'h0;
  endtask
  task rxn(input int k, input logic e);
    repeat (k) pulse(3'h4);
    repeat (2) @(posedge clk);
    check("rx stop", timer_active_flag, e);
  endtask

  // Start a run, rewrite reload mid-count, time the irq against the divide formula
  task run(input logic [7:0] md, input logic [7:0] pre, input logic ev, input logic [15:0] n, input logic [15:0] nw);
    int c;
    int x;
    wr(IDX_MODE, md);
    wr(IDX_PRE_LO, pre);
    wr(IDX_RLD_HI, n[15:8]);
    wr(IDX_RLD_LO, n[7:0]);
    wr(IDX_CTRL, {5'h0, ev, 2'b01});
    wr(IDX_RLD_HI, nw[15:8]);
    wr(IDX_RLD_LO, nw[7:0]);
    c = 6;
    while (timer_irq_flag !== 1'b1 && c < 6000) begin
      @(posedge clk);
      c++;
    end
    x = n * (2 * int'({md[3:0], pre}) + 1 + ev) * 125000 / 13560;
    check("period", c > x - 12 && c < x + 12, 1);
    check("running", timer_active_flag, md[4]);
    rd(IDX_CNT_LO, 8'h00, md[4]);
    rd(IDX_CNT_HI, 8'h00, md[4]);
    wr(IDX_CTRL, 8'h02);
    wr(IDX_STATUS, 8'h02);
    rd(IDX_STATUS, 8'h00, 0);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    foreach (rr[i]) rd(rr[i], 8'h00, 0);
    apb(0, 8'h00, 0, {2'b01, 32'h0});
    for (int i = 0; i < 8; i++) begin
      d = 8'(xs());
      wr(rr[i % 4], d);
      rd(rr[i % 4], d, 0);
    end
    d = 8'(xs());
    wr(IDX_CTRL, d & 8'h1c);
    rd(IDX_CTRL, d & 8'h1c, 0);
    run(8'h00, 8'h02, 0, 4, 4);
    run(8'h00, 8'h02, 1, 4, 4);
    run(8'h01, 8'h00, 0, 1, 1);
    run(8'h00, 8'h00, 0, 8, 200);
    run(8'h10, 8'h00, 0, 2, 2);
    // Gate closed with the other pins high, then opened
    for (int g = 1; g < 4; g++) begin
      gpin <= ~(3'h1 << (g - 1));
      wr(IDX_MODE, {1'b0, 2'(g), 5'h0});
      wr(IDX_RLD_HI, 8'h00);
      wr(IDX_RLD_LO, 8'h04);
      wr(IDX_CTRL, 8'h01);
      repeat (100) @(posedge clk);
      check("gated", {timer_active_flag, timer_irq_flag}, 2'b10);
      rd(IDX_CNT_LO, 8'h04, 0);
      rd(IDX_STATUS, 8'h01, 0);
      gpin <= 3'h1 << (g - 1);
      repeat (60) @(posedge clk);
      check("gate open", timer_irq_flag, 1);
      wr(IDX_CTRL, 8'h02);
      wr(IDX_STATUS, 8'h02);
    end
    wr(IDX_RLD_HI, 8'hff);
    wr(IDX_MODE, 8'h8f);
    wr(IDX_PRE_LO, 8'hff);
    wr(IDX_CTRL, 8'h00);
    rx_106_mode <= 1;
    pulse(3'h1);
    rxn(4, 1);
    rxn(1, 0);
    rx_106_mode <= 0;
    pulse(3'h2);
    rxn(0, 0);
    wr(IDX_CTRL, 8'h10);
    pulse(3'h2);
    rxn(3, 1);
    rxn(1, 0);
    wr(IDX_CTRL, 8'h18);
    pulse(3'h2);
    rxn(6, 1);
    wr(IDX_CTRL, 8'h1a);
    rxn(0, 0);
    results;
  end
endmodule // prt_timer_test
